// ---- pkg/modcfg_defines.vh ----
// Constants for the modulator configuration register bank
`ifndef MODCFG_DEFINES_VH
`define MODCFG_DEFINES_VH
`define REG_W            24
`define ADDR_W           6
`define MODCFG_ADDR      6'h06
`define INTFREQ_ADDR     6'h03
`define FRACFREQ_ADDR    6'h04
`define AUXLOAD_ADDR     6'h1A
`define MODCFG_RESET     24'h30F0A
`define INTFREQ_RESET    19'h00019
`define FRACFREQ_RESET   24'h000000
`define AUXLOAD_RESET    24'h000000
`define INTFREQ_W        19
`define ORDER_LSB        2
`define ORDER_MSB        3
`define RETIME_BIT       4
`define EXACT_BIT        5
`define BYPASS_BIT       7
`define AUTOSEED_BIT     8
`define CORE_EN_BIT      11
`define ORDER_FIRST      2'h0
`define ORDER_SECOND     2'h1
`define ORDER_THIRD      2'h2
`define ORDER_RSVD       2'h3
`define FRAME_BITS       6'h20
`define FRAME_CNT_W      6
`define HOLD_PD_CYCLES   2'h2
`endif

// ---- rtl/edge_pulse.v ----
// Rising and falling edge detector on a synchronised level
`timescale 1ns/1ns
`default_nettype none
module edge_pulse (
  input  wire ref_clk_in,
  input  wire resetn_in,
  input  wire level_in,
  output wire rise_out,
  output wire fall_out
);
  reg last_ff;

  // Remember previous level
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      last_ff <= 1'b0;
    end else begin
      last_ff <= level_in;
    end
  end

  assign rise_out = level_in & ~last_ff;
  assign fall_out = ~level_in & last_ff;
endmodule
`default_nettype wire

// ---- rtl/modulator_config_register.v ----
// Serial-loaded modulator configuration register with normal and retimed loading
// Serial frame: 24 data bits then 6 address bits then 2 spare bits, MSB first,
// sampled on serial clock rising edge while the frame strobe is low; the frame
// commits on the strobe rising edge. Serial pins are oversampled on ref_clk_in.
`timescale 1ns/1ns
`default_nettype none
`include "modcfg_defines.vh"
module modulator_config_register #(
  parameter REG_W = `REG_W
) (
  input  wire             ref_clk_in,
  input  wire             resetn_in,
  input  wire             serial_clk_in,
  input  wire             serial_data_in,
  input  wire             serial_frame_strobe_in,
  input  wire             phase_detector_clock_in,
  output reg  [REG_W-1:0] modulator_config_out,
  output reg  [1:0]       modulator_order_out,
  output reg              retimed_load_out,
  output reg              exact_freq_en_out,
  output reg              modulator_bypass_out,
  output reg              seed_on_write_out,
  output reg              core_enable_out,
  output reg              modulator_clock_en_out,
  output reg              use_modulator_out,
  output reg  [18:0]      int_freq_out,
  output reg  [REG_W-1:0] frac_freq_out,
  output reg  [REG_W-1:0] aux_load_out,
  output reg              seed_reload_out,
  output reg              order_reserved_out,
  output reg  [REG_W-1:0] read_data_out
);
  // Synchronised serial pins and detector clock
  wire sclk_sync;
  wire sdata_sync;
  wire strobe_sync;
  wire pd_sync;
  wire sclk_rise;
  wire strobe_rise;
  wire strobe_fall;
  wire pd_rise;

  sync2 u_sync_sclk (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .d_in       (serial_clk_in),
    .q_out      (sclk_sync)
  );
  sync2 u_sync_sdata (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .d_in       (serial_data_in),
    .q_out      (sdata_sync)
  );
  sync2 u_sync_strobe (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .d_in       (serial_frame_strobe_in),
    .q_out      (strobe_sync)
  );
  sync2 u_sync_pd (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .d_in       (phase_detector_clock_in),
    .q_out      (pd_sync)
  );

  edge_pulse u_edge_sclk (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .level_in   (sclk_sync),
    .rise_out   (sclk_rise),
    .fall_out   ()
  );
  edge_pulse u_edge_strobe (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .level_in   (strobe_sync),
    .rise_out   (strobe_rise),
    .fall_out   (strobe_fall)
  );
  edge_pulse u_edge_pd (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .level_in   (pd_sync),
    .rise_out   (pd_rise),
    .fall_out   ()
  );

  // Serial shifter and bit count
  reg  [31:0]             shift_ff;
  reg  [`FRAME_CNT_W-1:0] bit_cnt_ff;
  reg  [REG_W-1:0]        modcfg_ff;
  reg  [`ADDR_W-1:0]      rd_addr_ff;

  wire [REG_W-1:0]   frame_data = shift_ff[31:8];
  wire [`ADDR_W-1:0] frame_addr = shift_ff[7:2];
  wire               frame_ok   = (bit_cnt_ff == `FRAME_BITS);

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shift_ff   <= 32'h00000000;
      bit_cnt_ff <= {`FRAME_CNT_W{1'b0}};
    end else if (strobe_fall) begin
      bit_cnt_ff <= {`FRAME_CNT_W{1'b0}};
    end else if (!strobe_sync && sclk_rise) begin
      shift_ff <= {shift_ff[30:0], sdata_sync};
      if (bit_cnt_ff != `FRAME_BITS) begin
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
      end
    end
  end

  // Configuration register commits immediately at strobe rise
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      modcfg_ff <= `MODCFG_RESET;
    end else if (strobe_rise && frame_ok && frame_addr == `MODCFG_ADDR) begin
      modcfg_ff <= frame_data;
    end
  end

  // Frequency-class loads: immediate or held until next detector edge
  reg              pend_int_ff;
  reg              pend_frac_ff;
  reg              pend_aux_ff;
  reg [REG_W-1:0]  pend_data_ff;
  wire             is_int  = frame_addr == `INTFREQ_ADDR;
  wire             is_frac = frame_addr == `FRACFREQ_ADDR;
  wire             is_aux  = frame_addr == `AUXLOAD_ADDR;
  wire             commit  = strobe_rise && frame_ok;
  wire             retime  = modcfg_ff[`RETIME_BIT];
  wire             pending = pend_int_ff | pend_frac_ff | pend_aux_ff;

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend_int_ff  <= 1'b0;
      pend_frac_ff <= 1'b0;
      pend_aux_ff  <= 1'b0;
      pend_data_ff <= {REG_W{1'b0}};
    end else if (commit && retime && (is_int || is_frac || is_aux)) begin
      pend_int_ff  <= is_int;
      pend_frac_ff <= is_frac;
      pend_aux_ff  <= is_aux;
      pend_data_ff <= frame_data;
    end else if (pd_rise) begin
      pend_int_ff  <= 1'b0;
      pend_frac_ff <= 1'b0;
      pend_aux_ff  <= 1'b0;
    end
  end

  // Immediate path when not retiming, pending path on detector edge
  wire do_now   = commit && !retime;
  wire do_pd    = pending && pd_rise;
  wire ld_int   = (do_now && is_int) || (do_pd && pend_int_ff);
  wire ld_frac  = (do_now && is_frac) || (do_pd && pend_frac_ff);
  wire ld_aux   = (do_now && is_aux) || (do_pd && pend_aux_ff);
  wire [REG_W-1:0] ld_data = do_now ? frame_data : pend_data_ff;

  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      int_freq_out    <= `INTFREQ_RESET;
      frac_freq_out   <= `FRACFREQ_RESET;
      aux_load_out    <= `AUXLOAD_RESET;
      seed_reload_out <= 1'b0;
    end else begin
      seed_reload_out <= 1'b0;
      if (ld_int) begin
        int_freq_out <= ld_data[`INTFREQ_W-1:0];
      end
      if (ld_aux) begin
        aux_load_out <= ld_data;
      end
      if (ld_frac) begin
        frac_freq_out   <= ld_data;
        seed_reload_out <= modcfg_ff[`AUTOSEED_BIT];
      end
    end
  end

  // Read address latched from any frame's address field
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_addr_ff <= {`ADDR_W{1'b0}};
    end else if (commit) begin
      rd_addr_ff <= frame_addr;
    end
  end

  // Decoded configuration outputs, registered
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      modulator_config_out   <= `MODCFG_RESET;
      modulator_order_out    <= `ORDER_THIRD;
      retimed_load_out       <= 1'b0;
      exact_freq_en_out      <= 1'b0;
      modulator_bypass_out   <= 1'b0;
      seed_on_write_out      <= 1'b1;
      core_enable_out        <= 1'b1;
      modulator_clock_en_out <= 1'b1;
      use_modulator_out      <= 1'b1;
      order_reserved_out     <= 1'b0;
      read_data_out          <= {REG_W{1'b0}};
    end else begin
      modulator_config_out   <= modcfg_ff;
      modulator_order_out    <= modcfg_ff[`ORDER_MSB:`ORDER_LSB];
      order_reserved_out     <= modcfg_ff[`ORDER_MSB:`ORDER_LSB] == `ORDER_RSVD;
      retimed_load_out       <= retime;
      exact_freq_en_out      <= modcfg_ff[`EXACT_BIT];
      modulator_bypass_out   <= modcfg_ff[`BYPASS_BIT];
      seed_on_write_out      <= modcfg_ff[`AUTOSEED_BIT];
      core_enable_out        <= modcfg_ff[`CORE_EN_BIT];
      modulator_clock_en_out <= modcfg_ff[`CORE_EN_BIT];
      use_modulator_out      <= ~modcfg_ff[`BYPASS_BIT] & modcfg_ff[`CORE_EN_BIT];
      case (rd_addr_ff)
        `MODCFG_ADDR:   read_data_out <= modcfg_ff;
        `INTFREQ_ADDR:  read_data_out <= {5'h00, int_freq_out};
        `FRACFREQ_ADDR: read_data_out <= frac_freq_out;
        `AUXLOAD_ADDR:  read_data_out <= aux_load_out;
        default:        read_data_out <= {REG_W{1'b0}};
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- rtl/sync2.v ----
// Two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module sync2 (
  input  wire ref_clk_in,
  input  wire resetn_in,
  input  wire d_in,
  output wire q_out
);
  reg meta_ff;
  reg sync_ff;

  // First stage feeds only the second
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;
endmodule
`default_nettype wire

// ---- verif/modcfg_host.sv ----
// Serial-port host model that writes configuration frames
`timescale 1ns/1ns
`default_nettype none
module modcfg_host (
  input  wire logic clk_in,
  output logic      sclk_out,
  output logic      sdata_out,
  output logic      strobe_out
);
  // Idle: clock still, strobe high
  initial begin
    sclk_out   = 1'b0;
    sdata_out  = 1'b0;
    strobe_out = 1'b1;
  end
  // One frame of 24 data, 6 address and 2 spare bits, MSB first
  task automatic send(input logic [23:0] d, input logic [5:0] a);
    logic [31:0] f;
    f = {d, a, 2'h0};
    @(posedge clk_in) strobe_out <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk_in) sdata_out <= f[i];
      repeat (3) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (3) @(posedge clk_in);
    strobe_out <= 1'b1;
    repeat (24) @(posedge clk_in);
    sdata_out <= ~f[0];  // Released line shows the inverse level
    repeat (16) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// ---- verif/modcfg_sva.sv ----
// Checker for the modulator configuration register outputs
`timescale 1ns/1ns
`default_nettype none
module modcfg_sva #(
  parameter REG_W = 24
) (
  input wire logic             ref_clk_in,
  input wire logic             resetn_in,
  input wire logic             serial_frame_strobe_in,
  input wire logic             phase_detector_clock_in,
  input wire logic [REG_W-1:0] modulator_config_out,
  input wire logic [REG_W-1:0] frac_freq_out,
  input wire logic [1:0]       modulator_order_out,
  input wire logic             order_reserved_out,
  input wire logic             exact_freq_en_out,
  input wire logic             use_modulator_out,
  input wire logic             core_enable_out,
  input wire logic             modulator_clock_en_out,
  input wire logic             seed_reload_out,
  input wire logic             seed_on_write_out,
  input wire logic             retimed_load_out
);
  logic       pd_q;
  logic [3:0] pd_age;
  // Cycles since the detector clock last rose, saturating
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pd_q   <= 1'b0;
      pd_age <= 4'hF;
    end else begin
      pd_q   <= phase_detector_clock_in;
      pd_age <= (phase_detector_clock_in & ~pd_q) ? 4'h0 : pd_age + {3'h0, pd_age != 4'hF};
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  a_order_decode: assert property (
    modulator_order_out == modulator_config_out[3:2]) else $error("order field wrong");
  a_order_reserved: assert property (
    order_reserved_out == (modulator_order_out == 2'h3)) else $error("reserved flag wrong");
  a_exact_decode: assert property (
    exact_freq_en_out == modulator_config_out[5]) else $error("exact enable wrong");
  a_bypass_route: assert property (
    use_modulator_out == (!modulator_config_out[7] && modulator_config_out[11]))
    else $error("modulator routing wrong");
  a_core_clock: assert property (
    core_enable_out == modulator_config_out[11] && modulator_clock_en_out == core_enable_out)
    else $error("core enable wrong");
  a_seed_pulse: assert property (
    seed_reload_out |-> seed_on_write_out ##1 !seed_reload_out) else $error("seed pulse wrong");
  a_normal_load: assert property (
    !$stable(frac_freq_out) && !retimed_load_out |-> $past(serial_frame_strobe_in, 3))
    else $error("load before strobe rise");
  a_retime_wait: assert property (
    !$stable(frac_freq_out) && retimed_load_out |-> pd_age <= 4'h8)
    else $error("retimed load not after detector clock");
endmodule
bind modulator_config_register modcfg_sva #(.REG_W(REG_W)) chk_u (.ref_clk_in, .resetn_in,
  .serial_frame_strobe_in, .phase_detector_clock_in, .modulator_config_out, .frac_freq_out,
  .modulator_order_out, .order_reserved_out, .exact_freq_en_out, .use_modulator_out,
  .core_enable_out, .modulator_clock_en_out, .seed_reload_out, .seed_on_write_out,
  .retimed_load_out);
`default_nettype wire

// ---- verif/tb_modulator_config_register.sv ----
// Self-checking bench for the modulator configuration register
`timescale 1ns/1ns
`default_nettype none
`include "modcfg_defines.vh"
module tb_modulator_config_register;
  logic        ref_clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        pd_clk = 1'b0;
  logic        pd_run = 1'b1;
  logic        sclk, sdata, sstrb, rt, ex, byp, sow, ce, mce, usem, seedp, ordr;
  logic [23:0] cfg, frac, aux, rd, m_cfg, m_frac, m_aux, m_rd, pend_d;
  logic [18:0] intf, m_int;
  logic [5:0]  pend_a;
  logic [1:0]  ord;
  integer      error_cnt = 0;
  integer      checks = 0;
  integer      cycles = 0;
  integer      seed = 32'h6ce8fea8;
  integer      seed_cnt = 0;
  integer      m_seed_cnt = 0;
  modcfg_host host_u (.clk_in(ref_clk_in), .sclk_out(sclk), .sdata_out(sdata), .strobe_out(sstrb));
  modulator_config_register dut_u (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .serial_clk_in(sclk),
    .serial_data_in(sdata), .serial_frame_strobe_in(sstrb), .phase_detector_clock_in(pd_clk),
    .modulator_config_out(cfg), .modulator_order_out(ord), .retimed_load_out(rt),
    .exact_freq_en_out(ex), .modulator_bypass_out(byp), .seed_on_write_out(sow),
    .core_enable_out(ce), .modulator_clock_en_out(mce), .use_modulator_out(usem),
    .int_freq_out(intf), .frac_freq_out(frac), .aux_load_out(aux), .seed_reload_out(seedp),
    .order_reserved_out(ordr), .read_data_out(rd));
  // Reference clock and gated detector clock
  initial forever #4 ref_clk_in = ~ref_clk_in;
  initial forever #40 pd_clk = pd_run ? ~pd_clk : pd_clk;
  // Count seed reload pulses seen on the output
  always @(posedge ref_clk_in) begin
    if (seedp === 1'b1) begin
      seed_cnt <= seed_cnt + 1;
    end
  end
  // Run limit
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
  end
  function automatic logic [23:0] rnd;
    rnd = 24'($random(seed));
  endfunction
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compare every level output except read data with the model, plus the seed pulse count
  task automatic chk_all;
    chk("config", m_cfg, cfg);
    chk("order", m_cfg[3:2], ord);
    chk("reserved", m_cfg[3:2] == 2'h3, ordr);
    chk("exact", m_cfg[5], ex);
    chk("bypass", m_cfg[7], byp);
    chk("use", ~m_cfg[7] & m_cfg[11], usem);
    chk("seed", m_cfg[8], sow);
    chk("core", m_cfg[11], ce);
    chk("clock", m_cfg[11], mce);
    chk("retime", m_cfg[4], rt);
    chk("frac", m_frac, frac);
    chk("int", m_int, intf);
    chk("aux", m_aux, aux);
    chk("seed pulses", m_seed_cnt[23:0], seed_cnt[23:0]);
  endtask
  task automatic apply(input logic [23:0] v, input logic [5:0] a);
    case (a)
      `MODCFG_ADDR:   m_cfg = v;
      `INTFREQ_ADDR:  m_int = v[18:0];
      `FRACFREQ_ADDR: begin
        m_frac = v;
        m_seed_cnt = m_seed_cnt + m_cfg[8];
      end
      `AUXLOAD_ADDR:  m_aux = v;
      default:        v = 24'h0;
    endcase
    m_rd = (a == `INTFREQ_ADDR) ? {5'h00, v[18:0]} : v;
  endtask
  // Frame write; a retimed load is held while the detector clock is stopped
  task automatic wr(input logic [23:0] v, input logic [5:0] a);
    host_u.send(v, a);
    if (a != `MODCFG_ADDR && m_cfg[4] && !pd_run) begin
      pend_d = v;
      pend_a = a;
    end else begin
      apply(v, a);
      chk("readback", m_rd, rd);
    end
    chk_all;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    {m_cfg, m_int, m_frac, m_aux} = {`MODCFG_RESET, `INTFREQ_RESET, 48'h0};
    @(posedge ref_clk_in);
    #1 chk_all;
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      wr({19'(rnd()), 1'b0, k[1:0], 2'h0}, `MODCFG_ADDR);
    end
    $display("order test done");
    wr(rnd(), `FRACFREQ_ADDR);
    wr(rnd() & 24'h07FFFF, `INTFREQ_ADDR);
    wr(rnd(), `AUXLOAD_ADDR);
    wr(rnd(), 6'h2A);
    $display("normal load test done");
    wr(24'h30F18, `MODCFG_ADDR);
    pd_run = 1'b0;
    wr(rnd(), `FRACFREQ_ADDR);
    pd_run = 1'b1;
    repeat (30) @(posedge ref_clk_in);
    apply(pend_d, pend_a);
    chk("readback", m_rd, rd);
    chk_all;
    $display("retimed load test done");
    complete_run;
  end
endmodule
`default_nettype wire
